//--- common/qsr_pkg.sv
package qsr_pkg;

   // Opcodes fixed by the device
   localparam logic [7:0] OPC_PLAIN_READ    = 8'h03;
   localparam logic [7:0] OPC_PREFETCH_READ = 8'h0B;

   // Address space and header lengths in bits
   localparam int unsigned ADDR_W = 17;
   localparam logic [4:0] OPC_BITS  = 5'h08;
   localparam logic [4:0] ADDR_BITS = 5'h18;
   localparam logic [4:0] MODE_BITS = 5'h08;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // Mode byte upper nibble that keeps continuous read alive
   localparam logic [3:0] CONT_NIBBLE = 4'hA;

   // Lane widths, coded as the number of bits moved per clock
   localparam logic [2:0] LANE1 = 3'h1;
   localparam logic [2:0] LANE2 = 3'h2;
   localparam logic [2:0] LANE4 = 3'h4;

   // Decoded command word layout
   localparam int unsigned CMD_VALID = 8;
   localparam int unsigned CMD_AW_HI = 7;
   localparam int unsigned CMD_AW_LO = 5;
   localparam int unsigned CMD_DW_HI = 4;
   localparam int unsigned CMD_DW_LO = 2;
   localparam int unsigned CMD_MODE  = 1;
   localparam int unsigned CMD_DUMMY = 0;

   // Reset and idle values, and the burst address step
   localparam logic [8:0]  CMD_RST    = 9'h000;
   localparam logic [3:0]  IO_OE_IDLE = 4'hF;
   localparam logic [3:0]  IO_O_RST   = 4'h0;
   localparam logic [16:0] ADDR_RST   = 17'h00000;
   localparam logic [16:0] ADDR_STEP  = 17'h00001;

   typedef enum logic [2:0] {
      PH_OPCODE,
      PH_ADDR,
      PH_MODE,
      PH_DUMMY,
      PH_DATA,
      PH_IGNORE
   } qsr_phase_e;

endpackage

//--- logic/qsr_read_engine.sv
`timescale 1ns/10ps

module qsr_read_engine #(
   parameter logic [7:0] OPC_DUAL_OUT  = 8'h11,           // Dual output read opcode
   parameter logic [7:0] OPC_QUAD_OUT  = 8'h12,           // Four-lane output read opcode
   parameter logic [7:0] OPC_DUAL_ADDR = 8'h13,           // Dual address/data read opcode
   parameter logic [7:0] OPC_QUAD_ADDR = 8'h14            // Four-lane address/data read opcode
) (
   input  wire logic        sys_clk,                      // System clock, 40 MHz
   input  wire logic        sys_rst,                      // Synchronous reset, active high
   input  wire logic        store_busy_in,                // Nonvolatile store running
   input  wire logic        recall_busy_in,               // Nonvolatile recall running
   input  wire logic        two_lane_mode,                // Link in two-lane mode
   input  wire logic        four_lane_mode,               // Link in four-lane mode
   input  wire logic        quad_enable_bit,              // Nonvolatile wide-data enable
   input  wire logic        mem_wr_en,                    // Array write strobe
   input  wire logic [16:0] mem_wr_addr,                  // Array write address
   input  wire logic [7:0]  mem_wr_data,                  // Array write data
   output logic             busy_flag,                    // Status busy flag
   output logic             hardware_store_busy_pin_o,    // Store busy pin level
   output logic             hardware_store_busy_pin_oe_n, // Store busy pin enable, low drives
   output logic             continuous_read_state,        // Continuous read armed (link side)
   input  wire logic        sck,                          // Serial clock from host
   input  wire logic        cs_n,                         // Chip select, active low
   input  wire logic [3:0]  io_i,                         // Lane inputs, 0 = serial in
   output logic [3:0]       io_o,                         // Lane outputs, 1 = serial out
   output logic [3:0]       io_oe_n                       // Lane enables, low drives
);

   // Array: written on sys_clk, read asynchronously on the link side
   logic [7:0] mem_array [0:(1 << qsr_pkg::ADDR_W) - 1];

   // System domain
   logic        link_rst_reg;
   logic        busy_reg;
   logic        store_reg;
   logic [2:0]  lane_sys_reg;
   logic        qen_sys_reg;
   logic [2:0]  lane_sys_next;

   // Link domain, frame scoped (cleared by chip select high)
   qsr_pkg::qsr_phase_e phase_reg;
   qsr_pkg::qsr_phase_e phase_next;
   logic [4:0]  cnt_reg;
   logic [23:0] sh_reg;
   logic [16:0] start_addr_reg;
   logic        first_reg;
   logic [3:0]  rem_reg;
   logic [7:0]  out_sh_reg;
   logic [16:0] ptr_reg;
   logic [3:0]  io_o_reg;
   logic        drive_reg;

   // Link domain, persistent across frames
   logic [8:0]  cmd_reg;
   logic        cont_reg;
   logic [2:0]  lane_s1_reg;
   logic [2:0]  lane_s2_reg;
   logic        qen_s1_reg;
   logic        qen_s2_reg;
   logic        busy_s1_reg;
   logic        busy_s2_reg;

   function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [2:0] w,
                                            input logic [3:0] pins);
      case (w)
         qsr_pkg::LANE2: shift_in = {sh[21:0], pins[1:0]};
         qsr_pkg::LANE4: shift_in = {sh[19:0], pins[3:0]};
         default:        shift_in = {sh[22:0], pins[0]};
      endcase
   endfunction

   // Top bits of a byte placed on the lanes for width w
   function automatic logic [3:0] place(input logic [7:0] b, input logic [2:0] w);
      case (w)
         qsr_pkg::LANE2: place = {2'h0, b[7:6]};
         qsr_pkg::LANE4: place = b[7:4];
         default:        place = {2'h0, b[7], 1'b0};
      endcase
   endfunction

   function automatic logic [7:0] shl(input logic [7:0] b, input logic [2:0] w);
      case (w)
         qsr_pkg::LANE2: shl = {b[5:0], 2'h0};
         qsr_pkg::LANE4: shl = {b[3:0], 4'h0};
         default:        shl = {b[6:0], 1'b0};
      endcase
   endfunction

   // Returns {valid, addr width, data width, mode byte, dummy cycle}
   function automatic logic [8:0] decode(input logic [7:0] opc, input logic [2:0] lw,
                                         input logic qen, input logic busy);
      logic single;
      logic wide_ok;
      single  = (lw == qsr_pkg::LANE1);
      wide_ok = (lw != qsr_pkg::LANE4) | qen;
      decode  = qsr_pkg::CMD_RST;
      if (!busy) begin
         if (opc == qsr_pkg::OPC_PLAIN_READ && wide_ok) begin
            decode = {1'b1, lw, lw, 1'b0, !single};
         end else if (opc == qsr_pkg::OPC_PREFETCH_READ && wide_ok) begin
            decode = {1'b1, lw, lw, 1'b1, 1'b0};
         end else if (opc == OPC_DUAL_OUT && single) begin
            decode = {1'b1, qsr_pkg::LANE1, qsr_pkg::LANE2, 1'b1, 1'b0};
         end else if (opc == OPC_QUAD_OUT && single && qen) begin
            decode = {1'b1, qsr_pkg::LANE1, qsr_pkg::LANE4, 1'b1, 1'b0};
         end else if (opc == OPC_DUAL_ADDR && single) begin
            decode = {1'b1, qsr_pkg::LANE2, qsr_pkg::LANE2, 1'b1, 1'b0};
         end else if (opc == OPC_QUAD_ADDR && single && qen) begin
            decode = {1'b1, qsr_pkg::LANE4, qsr_pkg::LANE4, 1'b1, 1'b0};
         end
      end
   endfunction

   // ---------------- System domain ----------------
   assign lane_sys_next = four_lane_mode ? qsr_pkg::LANE4 :
                          two_lane_mode  ? qsr_pkg::LANE2 : qsr_pkg::LANE1;

   always_ff @(posedge sys_clk) begin
      link_rst_reg <= sys_rst;
      if (sys_rst) begin
         busy_reg     <= 1'b0;
         store_reg    <= 1'b0;
         lane_sys_reg <= qsr_pkg::LANE1;
         qen_sys_reg  <= 1'b0;
      end else begin
         busy_reg     <= store_busy_in | recall_busy_in;
         store_reg    <= store_busy_in;
         lane_sys_reg <= lane_sys_next;
         qen_sys_reg  <= quad_enable_bit;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (mem_wr_en) begin
         mem_array[mem_wr_addr] <= mem_wr_data;
      end
   end

   assign busy_flag                    = busy_reg;
   assign hardware_store_busy_pin_o    = 1'b0;
   assign hardware_store_busy_pin_oe_n = !store_reg;

   // ---------------- Link domain, rising edge ----------------
   // Levels are quasi-static; sck idles between frames, so a change needs two sck edges
   always_ff @(posedge sck or posedge link_rst_reg) begin
      if (link_rst_reg) begin
         lane_s1_reg <= qsr_pkg::LANE1;
         lane_s2_reg <= qsr_pkg::LANE1;
         qen_s1_reg  <= 1'b0;
         qen_s2_reg  <= 1'b0;
         busy_s1_reg <= 1'b0;
         busy_s2_reg <= 1'b0;
      end else begin
         lane_s1_reg <= lane_sys_reg;
         lane_s2_reg <= lane_s1_reg;
         qen_s1_reg  <= qen_sys_reg;
         qen_s2_reg  <= qen_s1_reg;
         busy_s1_reg <= busy_reg;
         busy_s2_reg <= busy_s1_reg;
      end
   end

   wire        opc_phase = (phase_reg == qsr_pkg::PH_OPCODE) && !cont_reg;
   wire        addr_phase = (phase_reg == qsr_pkg::PH_ADDR) ||
                            ((phase_reg == qsr_pkg::PH_OPCODE) && cont_reg);
   wire [2:0]  w_in = opc_phase ? lane_s2_reg : cmd_reg[qsr_pkg::CMD_AW_HI:qsr_pkg::CMD_AW_LO];
   wire [23:0] sh_next = shift_in(sh_reg, w_in, io_i);
   wire [4:0]  cnt_sum = 5'(cnt_reg + {2'h0, w_in});
   wire        opc_done = opc_phase && (cnt_sum == qsr_pkg::OPC_BITS);
   wire        addr_done = addr_phase && (cnt_sum == qsr_pkg::ADDR_BITS);
   wire        mode_done = (phase_reg == qsr_pkg::PH_MODE) && (cnt_sum == qsr_pkg::MODE_BITS);
   wire [8:0]  dec = decode(sh_next[7:0], lane_s2_reg, qen_s2_reg, busy_s2_reg);
   wire        cont_busy = cont_reg && busy_s2_reg && (phase_reg == qsr_pkg::PH_OPCODE);

   always_comb begin
      phase_next = phase_reg;
      case (phase_reg)
         qsr_pkg::PH_OPCODE,
         qsr_pkg::PH_ADDR: begin
            if (cont_busy) begin
               phase_next = qsr_pkg::PH_IGNORE;
            end else if (opc_done) begin
               phase_next = dec[qsr_pkg::CMD_VALID] ? qsr_pkg::PH_ADDR
                                                    : qsr_pkg::PH_IGNORE;
            end else if (addr_done) begin
               if (cmd_reg[qsr_pkg::CMD_MODE]) begin
                  phase_next = qsr_pkg::PH_MODE;
               end else if (cmd_reg[qsr_pkg::CMD_DUMMY]) begin
                  phase_next = qsr_pkg::PH_DUMMY;
               end else begin
                  phase_next = qsr_pkg::PH_DATA;
               end
            end
         end
         qsr_pkg::PH_MODE: begin
            if (mode_done) begin
               phase_next = qsr_pkg::PH_DATA;
            end
         end
         qsr_pkg::PH_DUMMY:  phase_next = qsr_pkg::PH_DATA;
         qsr_pkg::PH_DATA:   phase_next = qsr_pkg::PH_DATA;
         qsr_pkg::PH_IGNORE: phase_next = qsr_pkg::PH_IGNORE;
         default:            phase_next = qsr_pkg::PH_IGNORE;
      endcase
   end

   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         phase_reg      <= qsr_pkg::PH_OPCODE;
         cnt_reg        <= 5'h00;
         sh_reg         <= 24'h000000;
         start_addr_reg <= qsr_pkg::ADDR_RST;
      end else begin
         phase_reg <= phase_next;
         sh_reg    <= sh_next;
         cnt_reg   <= (opc_done || addr_done || mode_done) ? 5'h00 : cnt_sum;
         if (addr_done) begin
            start_addr_reg <= sh_next[16:0];
         end
      end
   end

   always_ff @(posedge sck or posedge link_rst_reg) begin
      if (link_rst_reg) begin
         cmd_reg  <= qsr_pkg::CMD_RST;
         cont_reg <= 1'b0;
      end else begin
         if (opc_done) begin
            cmd_reg <= dec;
         end
         if (mode_done) begin
            cont_reg <= (sh_next[7:4] == qsr_pkg::CONT_NIBBLE);
         end
      end
   end

   assign continuous_read_state = cont_reg;

   // ---------------- Link domain, falling edge ----------------
   wire [2:0]  dw = cmd_reg[qsr_pkg::CMD_DW_HI:qsr_pkg::CMD_DW_LO];
   wire        load_w = (phase_reg == qsr_pkg::PH_DATA) && (rem_reg == 4'h0);
   wire [16:0] data_addr_w = first_reg ? start_addr_reg : ptr_reg;
   wire [7:0]  mem_byte = mem_array[data_addr_w];
   wire [3:0]  oe_mask = (dw == qsr_pkg::LANE4) ? 4'hF :
                         (dw == qsr_pkg::LANE2) ? 4'h3 : 4'h2;

   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         first_reg  <= 1'b1;
         rem_reg    <= 4'h0;
         out_sh_reg <= 8'h00;
         ptr_reg    <= qsr_pkg::ADDR_RST;
         io_o_reg   <= qsr_pkg::IO_O_RST;
         drive_reg  <= 1'b0;
      end else if (load_w) begin
         io_o_reg   <= place(mem_byte, dw);
         out_sh_reg <= shl(mem_byte, dw);
         rem_reg    <= 4'(qsr_pkg::BYTE_BITS - {1'b0, dw});
         ptr_reg    <= 17'(data_addr_w + qsr_pkg::ADDR_STEP);
         first_reg  <= 1'b0;
         drive_reg  <= 1'b1;
      end else if (phase_reg == qsr_pkg::PH_DATA) begin
         io_o_reg   <= place(out_sh_reg, dw);
         out_sh_reg <= shl(out_sh_reg, dw);
         rem_reg    <= 4'(rem_reg - {1'b0, dw});
      end
   end

   assign io_o    = io_o_reg;
   assign io_oe_n = drive_reg ? ~oe_mask : qsr_pkg::IO_OE_IDLE;

   // ---------------- Checks ----------------
   AST_STORE_SHOWN: assert property (@(posedge sys_clk) disable iff (sys_rst)
      store_busy_in |=> busy_flag && !hardware_store_busy_pin_oe_n)
      else $error("store not shown on busy flag and pin");

   AST_IDLE_NOT_BUSY: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!store_busy_in && !recall_busy_in) |=> !busy_flag && hardware_store_busy_pin_oe_n)
      else $error("busy flag set without store or recall");

   AST_DESELECT_RELEASES: assert property (@(posedge sys_clk) disable iff (sys_rst)
      cs_n |-> (io_oe_n == qsr_pkg::IO_OE_IDLE))
      else $error("lanes driven while deselected");

   AST_BUSY_IGNORES: assert property (@(posedge sck) disable iff (cs_n)
      (opc_done && busy_s2_reg) |=> (phase_reg == qsr_pkg::PH_IGNORE) [*2])
      else $error("command accepted while busy");

   // The first byte loads on the falling edge in between, so the lanes are driven by then
   AST_MODE_TO_DATA: assert property (@(posedge sck) disable iff (cs_n)
      mode_done |=> (phase_reg == qsr_pkg::PH_DATA) && drive_reg && !first_reg)
      else $error("data not started at end of mode byte");

   AST_CONT_BUSY_IGNORES: assert property (@(posedge sck) disable iff (cs_n)
      cont_busy |=> (phase_reg == qsr_pkg::PH_IGNORE) && cont_reg)
      else $error("continuous frame accepted while busy");

   AST_DUMMY_CYCLE: assert property (@(posedge sck) disable iff (cs_n)
      (addr_done && cmd_reg[qsr_pkg::CMD_DUMMY])
         |=> (phase_reg == qsr_pkg::PH_DUMMY) ##1 (phase_reg == qsr_pkg::PH_DATA))
      else $error("multi-lane plain read lacks its dummy cycle");

   AST_CONT_ARMED: assert property (@(posedge sck) disable iff (cs_n)
      mode_done |=> (cont_reg == ($past(sh_next[7:4]) == qsr_pkg::CONT_NIBBLE)))
      else $error("continuous read state does not follow mode nibble");

   AST_ADDR_STEP: assert property (@(negedge sck) disable iff (cs_n)
      (load_w && !first_reg) |-> (data_addr_w == ptr_reg) ##1 (ptr_reg == 17'($past(data_addr_w) + 17'h00001)))
      else $error("burst address did not step by one");

   AST_MSB_FIRST: assert property (@(negedge sck) disable iff (cs_n)
      (load_w && dw == qsr_pkg::LANE1) |=> (io_o[1] == $past(mem_byte[7])) && (io_oe_n == 4'hD))
      else $error("serial data not MSB first on serial out");

   AST_QUAD_LANES: assert property (@(negedge sck) disable iff (cs_n)
      (load_w && dw == qsr_pkg::LANE4) |=> (io_o == $past(mem_byte[7:4])) && (io_oe_n == 4'h0))
      else $error("four-lane data not on lanes 3 to 0");

endmodule // qsr_read_engine

//--- testbench/qsr_host_model.sv
`timescale 1ns/10ps

module qsr_host_model (
   output logic            sck,     // Serial clock, idles low
   output logic            cs_n,    // Chip select, active low
   output wire logic [3:0] io_i,    // Resolved lane levels
   input  wire logic [3:0] io_o,    // Device lane data
   input  wire logic [3:0] io_oe_n  // Device lane enables, low drives
);
   logic [3:0] drv;
   logic [3:0] drv_en;
   logic [3:0] smp;
   logic [7:0] rx [0:3];
   logic       drove;

   // A released lane shows the inverse of its last value, never a friendly level
   assign io_i = (~io_oe_n & io_o) | (io_oe_n & drv_en & drv) | (io_oe_n & ~drv_en & ~drv);

   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      drv = 4'h0;
      drv_en = 4'h0;
      drove = 1'b0;
      // One edge with chip select high settles the frame logic at power-up
      pulse();
   end

   // 30 ns period keeps every read command inside its clock limit
   task automatic pulse();
      #15;
      if (io_oe_n !== 4'hF) drove = 1'b1;
      smp = io_i;
      sck = 1'b1;
      #15 sck = 1'b0;
   endtask

   task automatic send(input logic [23:0] v, input int nbits, input int w);
      logic [3:0] m;
      m = (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hF;
      for (int i = nbits - w; i >= 0; i -= w) begin
         drv_en = m;
         drv = 4'(v >> i) & m;
         pulse();
      end
   endtask

   task automatic frame(input logic [7:0] opc, input int ow, input logic [23:0] ad, input int aw,
                        input logic [7:0] md, input int mw, input int dum, input int dw,
                        input int nb);
      logic [7:0] b;
      drove = 1'b0;
      // Idle edges with chip select high let the link side see new settings
      repeat (3) pulse();
      #5 cs_n = 1'b0;
      if (ow != 0) send(24'(opc), 8, ow);
      send(ad, 24, aw);
      if (mw != 0) send(24'(md), 8, mw);
      drv_en = 4'h0;
      repeat (dum) pulse();
      b = 8'h00;
      for (int n = 0; n < nb; n++) begin
         for (int j = 0; j < 8; j += dw) begin
            pulse();
            b = (dw == 1) ? {b[6:0], smp[1]} : (dw == 2) ? {b[5:0], smp[1:0]} : {b[3:0], smp};
         end
         rx[n] = b;
      end
      #5 cs_n = 1'b1;
      // Let the release settle before anyone looks at the lanes
      #5;
   endtask
endmodule // qsr_host_model

//--- testbench/testbench.sv
`timescale 1ns/10ps

module testbench;
   localparam logic [7:0] OPC_DO = 8'h11;
   localparam logic [7:0] OPC_QO = 8'h12;
   localparam logic [7:0] OPC_DA = 8'h13;
   localparam logic [7:0] OPC_QA = 8'h14;
   typedef struct {
      logic [7:0]  opc;
      logic        two, four, qen;
      int          ow, aw, mw, dum, dw;
      logic [23:0] addr;
      logic        ok;
   } qsr_row_s;
   logic        sys_clk, sys_rst, store_busy_in, recall_busy_in;
   logic        two_lane_mode, four_lane_mode, quad_enable_bit, mem_wr_en;
   logic [16:0] mem_wr_addr;
   logic [7:0]  mem_wr_data;
   logic        busy_flag, pin_o, pin_oe_n, cont;
   wire         sck, cs_n;
   wire [3:0]   io_i, io_o, io_oe_n;
   int          errors, num_checks;
   qsr_row_s    rows [13];

   qsr_read_engine #(.OPC_DUAL_OUT(OPC_DO), .OPC_QUAD_OUT(OPC_QO), .OPC_DUAL_ADDR(OPC_DA),
      .OPC_QUAD_ADDR(OPC_QA)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .store_busy_in(store_busy_in), .recall_busy_in(recall_busy_in),
      .two_lane_mode(two_lane_mode), .four_lane_mode(four_lane_mode),
      .quad_enable_bit(quad_enable_bit), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
      .mem_wr_data(mem_wr_data), .busy_flag(busy_flag), .hardware_store_busy_pin_o(pin_o),
      .hardware_store_busy_pin_oe_n(pin_oe_n), .continuous_read_state(cont), .sck(sck),
      .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe_n(io_oe_n));
   qsr_host_model i_host (.sck(sck), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe_n(io_oe_n));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   function automatic logic [7:0] pat(input logic [16:0] x);
      return x[7:0] ^ x[15:8] ^ {x[16], 7'h35};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic fill(input logic [16:0] base);
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         mem_wr_en <= 1'b1;
         mem_wr_addr <= base + 17'(i);
         mem_wr_data <= pat(base + 17'(i));
      end
   endtask

   // Settings change only between frames; busy shows one sys_clk later
   task automatic cfg(input logic two, four, qen, st, rc);
      @(posedge sys_clk);
      two_lane_mode <= two;
      four_lane_mode <= four;
      quad_enable_bit <= qen;
      store_busy_in <= st;
      recall_busy_in <= rc;
      repeat (2) @(posedge sys_clk);
   endtask

   initial begin
      #400000;
      errors++;
      stop_test();
   end

   initial begin
      {sys_rst, store_busy_in, recall_busy_in, two_lane_mode} = 4'h8;
      {four_lane_mode, quad_enable_bit, mem_wr_en} = 3'h0;
      mem_wr_addr = 17'h00000;
      mem_wr_data = 8'h00;
      rows[0] = '{8'h03, 0, 0, 0, 1, 1, 0, 0, 1, 24'hFE0010, 1};
      rows[1] = '{8'h0B, 0, 0, 0, 1, 1, 1, 0, 1, 24'h01FFFF, 1};
      rows[2] = '{8'h03, 1, 0, 0, 2, 2, 0, 1, 2, 24'h000200, 1};
      rows[3] = '{8'h03, 0, 1, 1, 4, 4, 0, 1, 4, 24'h000300, 1};
      rows[4] = '{8'h0B, 1, 0, 0, 2, 2, 2, 0, 2, 24'h000400, 1};
      rows[5] = '{8'h0B, 0, 1, 1, 4, 4, 4, 0, 4, 24'h010500, 1};
      rows[6] = '{OPC_DO, 0, 0, 0, 1, 1, 1, 0, 2, 24'h000600, 1};
      rows[7] = '{OPC_QO, 0, 0, 1, 1, 1, 1, 0, 4, 24'h000700, 1};
      rows[8] = '{OPC_DA, 0, 0, 0, 1, 2, 2, 0, 2, 24'h000800, 1};
      rows[9] = '{OPC_QA, 0, 0, 1, 1, 4, 4, 0, 4, 24'h010900, 1};
      rows[10] = '{OPC_QO, 0, 0, 0, 1, 1, 1, 0, 4, 24'h000A00, 0};
      rows[11] = '{8'h5A, 0, 0, 0, 1, 1, 0, 0, 1, 24'h000B00, 0};
      rows[12] = '{OPC_DO, 1, 0, 0, 2, 2, 2, 0, 2, 24'h000C00, 0};
      repeat (16) @(posedge sys_clk);
      chk(busy_flag, 0);
      chk(pin_oe_n, 1);
      chk(io_oe_n, 4'hF);
      sys_rst <= 1'b0;
      foreach (rows[i]) fill(rows[i].addr[16:0]);
      fill(17'h00D00);
      fill(17'h00E00);
      @(posedge sys_clk);
      mem_wr_en <= 1'b0;
      foreach (rows[i]) begin
         cfg(rows[i].two, rows[i].four, rows[i].qen, 0, 0);
         i_host.frame(rows[i].opc, rows[i].ow, rows[i].addr, rows[i].aw, 8'h00, rows[i].mw,
                      rows[i].dum, rows[i].dw, 3);
         chk(i_host.drove, rows[i].ok);
         chk(io_oe_n, 4'hF);
         for (int b = 0; b < 3; b++)
            if (rows[i].ok) chk(i_host.rx[b], pat(rows[i].addr[16:0] + 17'(b)));
      end
      cfg(0, 0, 0, 1, 0);
      chk(busy_flag, 1);
      chk(pin_oe_n, 0);
      chk(pin_o, 0);
      i_host.frame(8'h03, 1, 24'h000D00, 1, 8'h00, 0, 0, 1, 1);
      chk(i_host.drove, 0);
      cfg(0, 0, 0, 0, 1);
      chk(busy_flag, 1);
      chk(pin_oe_n, 1);
      i_host.frame(8'h0B, 1, 24'h000D00, 1, 8'h00, 1, 0, 1, 1);
      chk(i_host.drove, 0);
      cfg(0, 0, 0, 0, 0);
      chk(busy_flag, 0);
      i_host.frame(8'h0B, 1, 24'h000D00, 1, 8'hA0, 1, 0, 1, 2);
      chk(cont, 1);
      chk(i_host.rx[1], pat(17'h00D01));
      chk(i_host.rx[0], pat(17'h00D00));
      // Busy at the start of a continuous frame: frame ignored, state kept
      cfg(0, 0, 0, 1, 0);
      i_host.frame(8'h00, 0, 24'h000E00, 1, 8'h50, 1, 0, 1, 2);
      chk(i_host.drove, 0);
      chk(cont, 1);
      cfg(0, 0, 0, 0, 0);
      // Continuous frame: address first, no opcode
      i_host.frame(8'h00, 0, 24'h000E00, 1, 8'h50, 1, 0, 1, 2);
      chk(i_host.rx[0], pat(17'h00E00));
      chk(i_host.rx[1], pat(17'h00E01));
      chk(cont, 0);
      i_host.frame(8'h03, 1, 24'h000D02, 1, 8'h00, 0, 0, 1, 1);
      chk(i_host.rx[0], pat(17'h00D02));
      // Reset in mid-run drops the continuous state
      i_host.frame(8'h0B, 1, 24'h000D00, 1, 8'hA0, 1, 0, 1, 1);
      chk(cont, 1);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk(cont, 0);
      chk(busy_flag, 0);
      chk(io_oe_n, 4'hF);
      sys_rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      i_host.frame(8'h03, 1, 24'h000D01, 1, 8'h00, 0, 0, 1, 1);
      chk(i_host.rx[0], pat(17'h00D01));
      stop_test();
   end
endmodule // testbench
